// [logic/strap_consts.svh]
// offsets, field positions, reset values and codes of the strap configuration latch
`ifndef STRAP_CONSTS_SVH
`define STRAP_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_BASIC_CTRL 6'h00
`define IDX_ADVERT 6'h04
`define IDX_OPMODE 6'h16
`define IDX_VENDOR_CTRL 6'h1f
`define IDX_STRAP_STAT 6'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BASIC_SPEED_BIT 13
`define BASIC_AUTONEG_BIT 12
`define BASIC_ISOLATE_BIT 10
`define ADVERT_100_BIT 7
`define OPMODE_BCAST_DIS_BIT 9
`define VENDOR_IND_LO 4
`define VENDOR_IND_HI 5

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define RST_ADDR_LO 3'h1
`define RST_CFG 3'h0
`define MGMT_ADDR_HI 2'h0
`define CFG_RMII 3'h1
`define CFG_RMII_B2B 3'h5
`define IND_MODE_RST 2'h0
`define IND_MODE_LINK_ACT 2'h0
`define IND_MODE_LINK 2'h1
`define BROADCAST_ADDR 5'h00

`endif

// [logic/strap_pkg.sv]
// types shared by the strap configuration latch
package strap_pkg;

	// one sample of every configuration strap pin
	typedef struct packed {
		logic [2:0] addr_lo;
		logic bcast_dis;
		logic [2:0] cfg;
		logic isolate;
		logic speed_100;
		logic autoneg;
	} strap_t;

	// decoded interface mode
	typedef enum logic [1:0] {
		IFACE_RMII,
		IFACE_RMII_B2B,
		IFACE_RESERVED
	} iface_mode_t;

endpackage : strap_pkg

// [logic/strap_sync.sv]
// two-stage synchroniser bank for asynchronous strap pins
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
	parameter int W = 10
) (
	// clock
	input wire logic clk,
	// asynchronous input and synchronised output
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// a bank of no bits cannot carry a strap
	if (W < 1) begin : g_w_check
		$error("W must be at least 1");
	end

	logic [W-1:0] meta_ff;

	// no reset: the chain must track the pins while reset is held
	always_ff @(posedge clk) begin
		meta_ff <= d;
		q <= meta_ff;
	end

endmodule : strap_sync

`default_nettype wire

// [logic/phy_strap_config_latch.sv]
// strap sampling at reset release, configuration registers and apb slave
`timescale 1ns/1ps
`default_nettype none
`include "strap_consts.svh"

module phy_strap_config_latch
	import strap_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// strap pins (asynchronous)
	input wire strap_t strap_pin,
	// shared pin drivers
	output logic pin_drive_en,
	output logic indicator_out_a,
	output logic indicator_out_a_oe,
	output logic indicator_out_b,
	output logic indicator_out_b_oe,
	// line status from the transceiver, same clock
	input wire logic link_up,
	input wire logic activity,
	// applied configuration
	output logic [4:0] mgmt_addr,
	output logic addr0_broadcast,
	output iface_mode_t iface_mode,
	output logic isolate,
	output logic speed_100,
	output logic autoneg_en,
	output logic adv_100
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (ADDR_W < 8) begin : g_addr_check
		$error("ADDR_W must be at least 8");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic iface_mode_t decode_cfg(input logic [2:0] cfg);
		if (cfg == `CFG_RMII)
			return IFACE_RMII;
		else if (cfg == `CFG_RMII_B2B)
			return IFACE_RMII_B2B;
		else
			return IFACE_RESERVED;
	endfunction : decode_cfg

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
		return a == ADDR_W'({idx, 2'b00});
	endfunction : hit

	// ----------------------------------------------------------------
	// strap synchronisation and capture
	// ----------------------------------------------------------------
	strap_t strap_s;
	strap_t strap_ff;
	logic done_ff;

	strap_sync #(
		.W($bits(strap_t))
	) u_sync (
		.clk(pclk),
		.d(strap_pin),
		.q(strap_s)
	);

	// one-shot capture
	// the chain runs through reset, so its output is settled at release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_ff <= 1'b0;
			strap_ff <= '{addr_lo: `RST_ADDR_LO, bcast_dis: 1'b0, cfg: `RST_CFG,
				isolate: 1'b0, speed_100: 1'b1, autoneg: 1'b1};
		end else if (!done_ff) begin
			done_ff <= 1'b1;
			strap_ff <= strap_s;
		end
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	logic wr_en;
	logic setup;
	logic mapped;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pwrite;
	assign mapped = hit(paddr, `IDX_BASIC_CTRL) | hit(paddr, `IDX_ADVERT) | hit(paddr, `IDX_OPMODE) |
		hit(paddr, `IDX_VENDOR_CTRL) | hit(paddr, `IDX_STRAP_STAT);
	// zero wait state: read data is prepared in the setup cycle
	assign pready = 1'b1;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic speed_ff;
	logic autoneg_ff;
	logic iso_ff;
	logic adv_ff;
	logic bcast_sw_ff;
	logic [1:0] ind_mode_ff;

	// straps load the basic control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_ff <= 1'b1;
			autoneg_ff <= 1'b1;
			iso_ff <= 1'b0;
		end else if (!done_ff) begin
			speed_ff <= strap_s.speed_100;
			autoneg_ff <= strap_s.autoneg;
			iso_ff <= strap_s.isolate;
		end else if (wr_en && hit(paddr, `IDX_BASIC_CTRL)) begin
			speed_ff <= pwdata[`BASIC_SPEED_BIT];
			autoneg_ff <= pwdata[`BASIC_AUTONEG_BIT];
			iso_ff <= pwdata[`BASIC_ISOLATE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adv_ff <= 1'b1;
		else if (!done_ff)
			adv_ff <= strap_s.speed_100;
		else if (wr_en && hit(paddr, `IDX_ADVERT))
			adv_ff <= pwdata[`ADVERT_100_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bcast_sw_ff <= 1'b0;
		else if (wr_en && hit(paddr, `IDX_OPMODE))
			bcast_sw_ff <= pwdata[`OPMODE_BCAST_DIS_BIT];
	end

	// indicator mode; reserved codes are refused
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ind_mode_ff <= `IND_MODE_RST;
		else if (wr_en && hit(paddr, `IDX_VENDOR_CTRL) && !pwdata[`VENDOR_IND_HI])
			ind_mode_ff <= pwdata[`VENDOR_IND_HI:`VENDOR_IND_LO];
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;

	// read mux, unused bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(paddr, `IDX_BASIC_CTRL)) begin
			rd_mux[`BASIC_SPEED_BIT] = speed_ff;
			rd_mux[`BASIC_AUTONEG_BIT] = autoneg_ff;
			rd_mux[`BASIC_ISOLATE_BIT] = iso_ff;
		end else if (hit(paddr, `IDX_ADVERT)) begin
			rd_mux[`ADVERT_100_BIT] = adv_ff;
		end else if (hit(paddr, `IDX_OPMODE)) begin
			rd_mux[`OPMODE_BCAST_DIS_BIT] = bcast_sw_ff;
		end else if (hit(paddr, `IDX_VENDOR_CTRL)) begin
			rd_mux[`VENDOR_IND_HI:`VENDOR_IND_LO] = ind_mode_ff;
		end else if (hit(paddr, `IDX_STRAP_STAT)) begin
			rd_mux[10:0] = {done_ff, strap_ff};
		end
	end

	// data and error prepared during setup, held through access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr <= ~mapped;
		end
	end

	// ----------------------------------------------------------------
	// applied configuration
	// ----------------------------------------------------------------
	// address from straps with fixed upper bits
	assign mgmt_addr = {`MGMT_ADDR_HI, strap_ff.addr_lo};
	// broadcast once the straps are taken, unless disabled by strap or software
	assign addr0_broadcast = done_ff & ~(strap_ff.bcast_dis | bcast_sw_ff);
	assign iface_mode = decode_cfg(strap_ff.cfg);
	assign isolate = iso_ff;
	assign speed_100 = speed_ff;
	assign autoneg_en = autoneg_ff;
	assign adv_100 = adv_ff;

	// ----------------------------------------------------------------
	// indicator pins (low is lit)
	// ----------------------------------------------------------------
	logic blink_ff;
	logic ind_a_ff;
	logic ind_b_ff;

	// blink phase advances only while there is traffic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			blink_ff <= 1'b0;
		else if (activity)
			blink_ff <= ~blink_ff;
	end

	// reserved modes never reach here, the field refuses them
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ind_a_ff <= 1'b1;
			ind_b_ff <= 1'b1;
		end else if (ind_mode_ff == `IND_MODE_LINK) begin
			ind_a_ff <= ~link_up;
			ind_b_ff <= activity ? blink_ff : 1'b1;
		end else begin
			ind_a_ff <= link_up ? (activity & blink_ff) : 1'b1;
			ind_b_ff <= ~speed_ff;
		end
	end

	assign indicator_out_a = ind_a_ff;
	assign indicator_out_b = ind_b_ff;
	// drivers off until the straps are taken
	assign pin_drive_en = done_ff;
	assign indicator_out_a_oe = done_ff;
	assign indicator_out_b_oe = done_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_capture_once; !done_ff |=> done_ff && strap_ff == $past(strap_s); endproperty
	a_capture_once: assert property (p_capture_once) else $error("straps not captured at release");
	property p_hold; done_ff |=> $stable(strap_ff) && done_ff; endproperty
	a_hold: assert property (p_hold) else $error("latched straps changed");
	property p_addr; !done_ff |=> mgmt_addr[2:0] == $past(strap_s.addr_lo); endproperty
	a_addr: assert property (p_addr) else $error("management address wrong");
	property p_addr_hi; $rose(done_ff) |-> mgmt_addr[4:3] == 2'h0 [*3]; endproperty
	a_addr_hi: assert property (p_addr_hi) else $error("upper address bits set");
	property p_bcast; !done_ff |=> addr0_broadcast == !$past(strap_s.bcast_dis); endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast state wrong");
	property p_sw_disable; wr_en && hit(paddr, `IDX_OPMODE) && pwdata[`OPMODE_BCAST_DIS_BIT]
		|=> !addr0_broadcast; endproperty
	a_sw_disable: assert property (p_sw_disable) else $error("software disable ignored");
	property p_default_bcast; done_ff && !strap_ff.bcast_dis && !bcast_sw_ff |-> addr0_broadcast; endproperty
	a_default_bcast: assert property (p_default_bcast) else $error("address zero not broadcast");
	property p_mode; (strap_ff.cfg == `CFG_RMII) == (iface_mode == IFACE_RMII) &&
		(strap_ff.cfg == `CFG_RMII_B2B) == (iface_mode == IFACE_RMII_B2B); endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong");
	property p_iso; !done_ff |=> isolate == $past(strap_s.isolate); endproperty
	a_iso: assert property (p_iso) else $error("isolate not loaded");
	property p_speed; !done_ff |=> speed_100 == $past(strap_s.speed_100) &&
		adv_100 == $past(strap_s.speed_100); endproperty
	a_speed: assert property (p_speed) else $error("speed not loaded");
	property p_ind_rsvd; wr_en && hit(paddr, `IDX_VENDOR_CTRL) && pwdata[`VENDOR_IND_HI]
		|=> $stable(ind_mode_ff); endproperty
	a_ind_rsvd: assert property (p_ind_rsvd) else $error("reserved indicator mode taken");
	property p_oe_off; !done_ff |-> !pin_drive_en && !indicator_out_a_oe && !indicator_out_b_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven before capture");
	c_capture: cover property ($rose(done_ff));
	c_sw_disable: cover property (addr0_broadcast ##1 !addr0_broadcast);
	c_b2b: cover property (done_ff && iface_mode == IFACE_RMII_B2B);
	c_unmapped: cover property (psel && penable && pslverr);

endmodule : phy_strap_config_latch

`default_nettype wire

// [testbench/strap_board_model.sv]
// board pull resistors and mac side of the shared strap pins
`timescale 1ns/1ps
`default_nettype none

module strap_board_model
	import strap_pkg::*;
(
	// board strap setting and device drive state
	input wire strap_t pulls,
	input wire logic drive_en,
	// level seen on the strap pins
	output strap_t pin_level
);
	// pulls only set the level while the device drivers are off
	// afterwards the mac side drives the inverse, so a late capture shows up
	assign pin_level = drive_en ? strap_t'(~pulls) : pulls;
endmodule : strap_board_model
`default_nettype wire

// [testbench/phy_strap_config_latch_test.sv]
// self-checking bench of the strap configuration latch
`timescale 1ns/1ps
`default_nettype none

module phy_strap_config_latch_test;
	import strap_pkg::*;
	typedef struct {strap_t s; iface_mode_t m;} row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, link_up = 0, activity = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, er, pin_drive_en, ia, ia_oe, ib, ib_oe, isolate, speed_100, autoneg_en, adv_100, bc;
	logic [4:0] mgmt_addr;
	logic b0;
	iface_mode_t iface_mode;
	strap_t pulls = strap_t'(10'h083), pins;
	int fails = 0, n_compared = 0, cyc = 0;
	row_t rows[5] = '{'{10'h083, IFACE_RESERVED}, '{10'h3cc, IFACE_RMII}, '{10'h02a, IFACE_RMII_B2B},
		'{10'h2fd, IFACE_RESERVED}, '{10'h123, IFACE_RESERVED}};

	always #10 pclk = ~pclk;

	strap_board_model u_board (.pulls(pulls), .drive_en(pin_drive_en), .pin_level(pins));
	phy_strap_config_latch u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .strap_pin(pins), .pin_drive_en(pin_drive_en), .indicator_out_a(ia),
		.indicator_out_a_oe(ia_oe), .indicator_out_b(ib), .indicator_out_b_oe(ib_oe), .link_up(link_up),
		.activity(activity), .mgmt_addr(mgmt_addr), .addr0_broadcast(bc), .iface_mode(iface_mode),
		.isolate(isolate), .speed_100(speed_100), .autoneg_en(autoneg_en), .adv_100(adv_100));

	task chk(input logic ok, input string m);
		n_compared++;
		if (ok !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk

	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		// one idle edge, so the next call never reassigns psel in this time step
		@(posedge pclk);
	endtask : apb

	task do_reset;
		presetn <= 0;
		repeat (16) @(posedge pclk);
		chk(pin_drive_en === 1'b0 && ia_oe === 1'b0 && ib_oe === 1'b0, "drivers on in reset");
		presetn <= 1;
		repeat (4) @(posedge pclk);
		chk(pin_drive_en === 1'b1 && ia_oe === 1'b1 && ib_oe === 1'b1, "drivers off after capture");
	endtask : do_reset

	task stop_test;
		$display("fails %0d n_compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end

	initial begin
		// strap rows: each reset captures one board setting
		foreach (rows[i]) begin
			pulls <= rows[i].s;
			do_reset();
			chk(mgmt_addr === {2'b00, rows[i].s.addr_lo}, "address");
			chk(iface_mode === rows[i].m, "mode");
			chk(isolate === rows[i].s.isolate, "isolate");
			chk(speed_100 === rows[i].s.speed_100 && adv_100 === rows[i].s.speed_100, "speed");
			chk(autoneg_en === rows[i].s.autoneg, "autoneg");
			chk(bc === ~rows[i].s.bcast_dis, "broadcast");
			chk(ib === ~rows[i].s.speed_100 && ia === 1'b1, "indicators");
			apb(1'b0, 8'h80, 32'h0);
			chk(rd[10:0] === {1'b1, rows[i].s} && pins !== rows[i].s, "capture held");
			apb(1'b0, 8'h00, 32'h0);
			chk(rd[13] === rows[i].s.speed_100 && rd[10] === rows[i].s.isolate, "basic ctrl");
			chk(er === 1'b0 && pready === 1'b1, "mapped read");
		end
		// software broadcast disable on the default strap
		pulls <= strap_t'(10'h083);
		do_reset();
		apb(1'b1, 8'h58, 32'h200);
		@(posedge pclk);
		chk(bc === 1'b0, "sw disable");
		apb(1'b1, 8'h58, 32'h0);
		@(posedge pclk);
		chk(bc === 1'b1, "sw enable");
		// software overrides the strapped bits, the status word keeps the straps
		apb(1'b1, 8'h00, 32'h0000_0400);
		apb(1'b1, 8'h10, 32'h0);
		chk(isolate === 1'b1 && speed_100 === 1'b0 && autoneg_en === 1'b0 && adv_100 === 1'b0, "sw override");
		apb(1'b0, 8'h80, 32'h0);
		chk(rd[10:0] === 11'h483, "strap status kept");
		// unmapped address
		apb(1'b0, 8'h40, 32'h0);
		chk(er === 1'b1, "no error");
		// indicator mode 01: link on a, activity blink on b
		apb(1'b1, 8'h7c, 32'h10);
		link_up <= 1;
		repeat (3) @(posedge pclk);
		chk(ia === 1'b0 && ib === 1'b1, "indicator link");
		activity <= 1;
		repeat (2) @(posedge pclk);
		b0 = ib;
		@(posedge pclk);
		chk(ib === ~b0, "activity blink");
		activity <= 0;
		// reserved code refused
		apb(1'b1, 8'h7c, 32'h20);
		apb(1'b0, 8'h7c, 32'h0);
		chk(rd[5:4] === 2'b01, "reserved mode");
		stop_test();
	end
endmodule : phy_strap_config_latch_test
`default_nettype wire
